// ---- design/scc_defs.vh ----
`ifndef SCC_DEFS_VH
`define SCC_DEFS_VH
// ----------------------------------------------------------------
// register map (word index times four)
// ----------------------------------------------------------------
`define SCC_ADR_CTRL 8'h00
`define SCC_ADR_STATUS 8'h04
`define SCC_ADR_REMOTE 8'h08
`define SCC_ADR_MODE 8'h0C
`define SCC_ADR_FAULT 8'h10
`define SCC_ADR_ID 8'h14
// ctrl register fields
`define SCC_CTRL_TEST_START 0
`define SCC_CTRL_TEST_STOP 1
`define SCC_CTRL_FAULT_SET 2
`define SCC_CTRL_COMM 3
// status register fields
`define SCC_ST_SAFETY 0
`define SCC_ST_GENERAL 1
`define SCC_ST_TEST 2
`define SCC_ST_FAULT 3
`define SCC_ST_ADR_OK 4
`define SCC_ST_SEQ_LSB 8
// ----------------------------------------------------------------
// timing, valid address range and device identity
// ----------------------------------------------------------------
`define SCC_CLK_HZ 125000000
`define SCC_DEAD_MS 300
`define SCC_DEAD_CYC (`SCC_CLK_HZ / 1000 * `SCC_DEAD_MS)
`define SCC_DEB_US 10000
`define SCC_DEB_CYC (`SCC_CLK_HZ / 1000000 * `SCC_DEB_US)
`define SCC_CAL_US 50000
`define SCC_CAL_CYC (`SCC_CLK_HZ / 1000000 * `SCC_CAL_US)
`define SCC_BUS_US 100000
`define SCC_BUS_CYC (`SCC_CLK_HZ / 1000000 * `SCC_BUS_US)
`define SCC_ADR_MIN 10'h001
`define SCC_ADR_MAX 10'h3E7
`define SCC_DEVICE_ID 32'h5C0C0001
`endif

// ---- design/scc_top.v ----
// Notes on behaviour
// - open active supply, dead gap, close other
// - changeover contact idle on general supply
// - each channel steady or ready by switch
// - monitor switch off masks channel faults
// - light-switch input switches its channel relay
// - open test contact acts as supply loss
// - unit/button test keeps general supply, checks channels
// - respond only to rotary address 1..999; reads are answered at any address
// - bus indicator lit during communication
// - test indicator during test; error sets fault
// - supply indicators show feeding supply
// - general supply loss forces all channels on
// - test turns all on, then restore targets
// - calibrate: all open, zero, supply, channels, measure
// - detection range 0.07 A to 6 A
// - steady channels ignore remote switching
// - button press toggles manual test mode
// - remote on/off only from central unit
// - per-channel indicator shows switching state
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
`include "scc_defs.vh"
module scc_top #(
  parameter NCH = 8,
  parameter DEAD_CYC = `SCC_DEAD_CYC,
  parameter DEB_CYC = `SCC_DEB_CYC,
  parameter CAL_CYC = `SCC_CAL_CYC,
  parameter BUS_CYC = `SCC_BUS_CYC,
  parameter [31:0] DEVICE_ID = `SCC_DEVICE_ID // arbitrary value
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // pins from the field
  input wire general_ok_i,
  input wire test_contact_i,
  input wire test_button_i,
  input wire [NCH-1:0] light_switch_i,
  input wire [NCH-1:0] mode_switch_i,
  input wire [NCH-1:0] monitor_en_i,
  input wire [9:0] rotary_adr_i,
  input wire [NCH-1:0] current_ok_i,
  // relays
  output reg general_relay_o,
  output reg safety_relay_o,
  output reg changeover_contact_o,
  output reg [NCH-1:0] channel_relay_o,
  output reg cal_zero_o,
  // indicators
  output reg led_bus_o,
  output reg led_test_o,
  output reg led_fault_o,
  output reg led_general_o,
  output reg led_safety_o,
  output reg [NCH-1:0] led_channel_o
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [3:0] SUP_GEN = 4'h1;
  localparam [3:0] SUP_GAP_S = 4'h2;
  localparam [3:0] SUP_SAF = 4'h4;
  localparam [3:0] SUP_GAP_G = 4'h8;
  localparam [4:0] TS_IDLE = 5'h01;
  localparam [4:0] TS_OPEN = 5'h02;
  localparam [4:0] TS_SUP = 5'h04;
  localparam [4:0] TS_CHAN = 5'h08;
  localparam [4:0] TS_MEAS = 5'h10;

  // ----------------------------------------------------------------
  // overview for the next engineer
  // ----------------------------------------------------------------
  // the block is split into five parts, spread over seven sections:
  //   synchronisers for every field pin and debounce of button and test contact,
  //   a wishbone slave that stands in for the building-bus interface,
  //   the supply changeover with its dead gap,
  //   the test sequencer with its calibration phases,
  //   channel targets and the registered outputs.
  // register map, byte offsets on the slave:
  //   ctrl   (w)  b0 start test, b1 stop test, b3 bus activity
  //   status (r)  b0 safety, b1 general, b2 test, b3 fault,
  //               b4 address valid, b12:8 test state
  //   remote (rw) one channel-on bit per channel
  //   mode   (r)  [15:8] channel drive, [7:0] steady switches
  //   fault  (r)  per-channel faults latched during a test
  //   id     (r)  device identity word
  // every access is answered one cycle after it is taken, even for
  // unmapped offsets, so a master never hangs on a bad address.
  // writes are dropped while the rotary address is outside 1..999,
  // which keeps an unaddressed unit from acting on stray traffic.
  // timing counts are parameters so a bench can shorten them; the
  // defaults give the full dead gap, debounce and calibration times.

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam NS = 3 + 3 * NCH + 10;
  wire [NS-1:0] raw_w = {general_ok_i, test_contact_i, test_button_i, light_switch_i,
    mode_switch_i, monitor_en_i, rotary_adr_i};
  // reset to the idle pin levels: supply present, test contact closed.
  // resetting these to zero would fake a supply loss and start a
  // changeover straight out of reset.
  localparam [NS-1:0] SYNC_IDLE = {2'b11, {(NS-2){1'b0}}};
  reg [NS-1:0] s1_reg;
  reg [NS-1:0] s2_reg;
  // first stage feeds only the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= SYNC_IDLE;
      s2_reg <= SYNC_IDLE;
    end else begin
      s1_reg <= raw_w;
      s2_reg <= s1_reg;
    end
  end
  wire gen_ok_w = s2_reg[NS-1];
  wire contact_w = s2_reg[NS-2];
  wire button_w = s2_reg[NS-3];
  wire [NCH-1:0] lsw_w = s2_reg[3*NCH+9:2*NCH+10];
  wire [NCH-1:0] steady_w = s2_reg[2*NCH+9:NCH+10];
  wire [NCH-1:0] mon_w = s2_reg[NCH+9:10];
  wire [9:0] adr_w = s2_reg[9:0];
  // the current comparators are outside this clock domain too; they
  // only matter in the measure phase, so the two cycles cost nothing
  reg [NCH-1:0] cur_s1_reg;
  reg [NCH-1:0] cur_s2_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cur_s1_reg <= {NCH{1'b1}};
      cur_s2_reg <= {NCH{1'b1}};
    end else begin
      cur_s1_reg <= current_ok_i;
      cur_s2_reg <= cur_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // debounce of button and test contact
  // ----------------------------------------------------------------
  // bit 0 is the button, bit 1 the test contact
  wire [1:0] db_w;
  wire [1:0] db_in_w = {contact_w, button_w};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_deb
      reg [31:0] cnt_reg;
      reg lvl_reg;
      // level must stand DEB_CYC cycles before it is accepted;
      // chatter restarts the count, so only a clean level passes
      always @(posedge clk_i) begin
        if (rst_i) begin
          cnt_reg <= 32'h00000000;
          lvl_reg <= (gi == 1); // contact closed assumed at reset
        end else if (db_in_w[gi] == lvl_reg) begin
          cnt_reg <= 32'h00000000;
        end else if (cnt_reg >= DEB_CYC - 1) begin
          cnt_reg <= 32'h00000000;
          lvl_reg <= db_in_w[gi];
        end else begin
          cnt_reg <= cnt_reg + 32'h00000001;
        end
      end
      assign db_w[gi] = lvl_reg;
    end
  endgenerate
  reg button_d_reg;
  always @(posedge clk_i) begin
    if (rst_i) button_d_reg <= 1'b0;
    else button_d_reg <= db_w[0];
  end
  wire press_w = db_w[0] & ~button_d_reg;

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  wire adr_ok_w = (adr_w >= `SCC_ADR_MIN) && (adr_w <= `SCC_ADR_MAX);
  wire req_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_w = req_w & wb_we_i & wb_sel_i[0];
  reg [NCH-1:0] remote_reg;
  reg test_req_reg;
  reg test_stop_reg;
  reg fault_reg;
  reg [NCH-1:0] fault_ch_reg;
  reg [31:0] bus_cnt_reg;
  reg [3:0] sup_reg;
  reg [4:0] ts_reg;
  reg test_on_reg;
  reg [NCH-1:0] ch_reg;
  // the answer is registered, so a held request is taken only once:
  // ack itself masks the request in the cycle it stands
  // one-wait-state answer, registers only accept with a valid address
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      remote_reg <= {NCH{1'b0}};
      test_req_reg <= 1'b0;
      test_stop_reg <= 1'b0;
      bus_cnt_reg <= 32'h00000000;
    end else begin
      wb_ack_o <= req_w;
      test_req_reg <= 1'b0;
      test_stop_reg <= 1'b0;
      if (bus_cnt_reg != 32'h00000000) bus_cnt_reg <= bus_cnt_reg - 32'h00000001;
      if (wr_w && adr_ok_w) begin
        case (wb_adr_i)
          `SCC_ADR_CTRL: begin
            test_req_reg <= wb_dat_i[`SCC_CTRL_TEST_START];
            test_stop_reg <= wb_dat_i[`SCC_CTRL_TEST_STOP];
            if (wb_dat_i[`SCC_CTRL_COMM]) bus_cnt_reg <= BUS_CYC;
          end
          `SCC_ADR_REMOTE: remote_reg <= wb_dat_i[NCH-1:0];
          default: ;
        endcase
      end
      if (req_w) begin
        case (wb_adr_i)
          `SCC_ADR_STATUS: wb_dat_o <= {16'h0000, 3'h0, ts_reg, 3'h0, adr_ok_w,
            fault_reg, test_on_reg, sup_reg == SUP_GEN, sup_reg == SUP_SAF};
          `SCC_ADR_REMOTE: wb_dat_o <= {{(32-NCH){1'b0}}, remote_reg};
          `SCC_ADR_MODE: wb_dat_o <= {{(32-2*NCH){1'b0}}, ch_reg, steady_w};
          `SCC_ADR_FAULT: wb_dat_o <= {{(32-NCH){1'b0}}, fault_ch_reg};
          `SCC_ADR_ID: wb_dat_o <= DEVICE_ID;
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // supply changeover
  // ----------------------------------------------------------------
  // sequence on a request for safety: the general relay opens at once,
  // both relays stay open for the dead gap, then the safety relay
  // closes. the return is symmetric. a request that goes away in the
  // middle of a gap is only acted on after the gap has run out, so the
  // two supplies can never be bridged by a fast toggle.
  // loss of general supply or an open test contact both ask for safety
  wire want_safety_w = ~gen_ok_w | ~db_w[1];
  reg [31:0] gap_cnt_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      sup_reg <= SUP_GEN;
      gap_cnt_reg <= 32'h00000000;
    end else begin
      case (sup_reg)
        SUP_GEN: if (want_safety_w) begin
          sup_reg <= SUP_GAP_S;
          gap_cnt_reg <= 32'h00000000;
        end
        SUP_GAP_S: if (gap_cnt_reg >= DEAD_CYC - 1) sup_reg <= SUP_SAF;
          else gap_cnt_reg <= gap_cnt_reg + 32'h00000001;
        SUP_SAF: if (!want_safety_w) begin
          sup_reg <= SUP_GAP_G;
          gap_cnt_reg <= 32'h00000000;
        end
        SUP_GAP_G: if (gap_cnt_reg >= DEAD_CYC - 1) sup_reg <= SUP_GEN;
          else gap_cnt_reg <= gap_cnt_reg + 32'h00000001;
        default: sup_reg <= SUP_GEN;
      endcase
    end
  end
  wire on_safety_w = (sup_reg == SUP_GAP_S) || (sup_reg == SUP_SAF);

  // ----------------------------------------------------------------
  // test sequencer with calibration
  // ----------------------------------------------------------------
  // phases: open (all relays and general supply off, zero readings
  // taken), sup (general back on, channels still open), chan (channels
  // closed, inrush allowed to settle), meas (faults latched until the
  // next start). a button press or a stop write ends the test from any
  // phase; a start write while a test runs is ignored on purpose, so
  // a repeated command from the central unit cannot cut a test short.
  // supply changeover is not touched here: the test never switches to safety supply
  reg [31:0] cal_cnt_reg;
  wire cal_done_w = cal_cnt_reg >= CAL_CYC - 1;
  wire toggle_w = press_w | test_req_reg | (test_stop_reg & test_on_reg);
  always @(posedge clk_i) begin
    if (rst_i) begin
      ts_reg <= TS_IDLE;
      test_on_reg <= 1'b0;
      fault_reg <= 1'b0;
      fault_ch_reg <= {NCH{1'b0}};
      cal_cnt_reg <= 32'h00000000;
    end else begin
      cal_cnt_reg <= cal_cnt_reg + 32'h00000001;
      if (test_on_reg && toggle_w && !test_req_reg) begin
        ts_reg <= TS_IDLE; // second press leaves
        test_on_reg <= 1'b0;
      end else begin
        case (ts_reg)
          TS_IDLE: if (toggle_w && !test_on_reg) begin
            ts_reg <= TS_OPEN;
            test_on_reg <= 1'b1;
            fault_reg <= 1'b0;
            fault_ch_reg <= {NCH{1'b0}};
            cal_cnt_reg <= 32'h00000000;
          end
          TS_OPEN: if (cal_done_w) begin
            ts_reg <= TS_SUP; // zeros stored
            cal_cnt_reg <= 32'h00000000;
          end
          TS_SUP: if (cal_done_w) begin
            ts_reg <= TS_CHAN;
            cal_cnt_reg <= 32'h00000000;
          end
          TS_CHAN: if (cal_done_w) ts_reg <= TS_MEAS;
          TS_MEAS: begin
            // current_ok_i low means below 0.07 A or above 6 A
            fault_ch_reg <= fault_ch_reg | (~cur_s2_reg & mon_w);
            if (|(~cur_s2_reg & mon_w)) fault_reg <= 1'b1;
          end
          default: ts_reg <= TS_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // channel targets and relays
  // ----------------------------------------------------------------
  // priority: calibration opens everything, then test and supply loss
  // force all on, otherwise the programmed target drives the relay.
  // limitation: a test started on the safety supply still opens the
  // channels during calibration.
  // target survives the test untouched, so restoring is automatic
  wire [NCH-1:0] target_w = steady_w | lsw_w | (remote_reg & ~steady_w);
  always @* begin
    if (ts_reg == TS_OPEN || ts_reg == TS_SUP) ch_reg = {NCH{1'b0}};
    else if (test_on_reg) ch_reg = {NCH{1'b1}};
    else if (on_safety_w) ch_reg = {NCH{1'b1}};
    else ch_reg = target_w;
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // every output is a flip-flop so relay coils and leds see no glitch
  // from the decode above; the cost is one cycle of latency.
  always @(posedge clk_i) begin
    if (rst_i) begin
      general_relay_o <= 1'b0;
      safety_relay_o <= 1'b0;
      changeover_contact_o <= 1'b0;
      channel_relay_o <= {NCH{1'b0}};
      cal_zero_o <= 1'b0;
      led_bus_o <= 1'b0;
      led_test_o <= 1'b0;
      led_fault_o <= 1'b0;
      led_general_o <= 1'b0;
      led_safety_o <= 1'b0;
      led_channel_o <= {NCH{1'b0}};
    end else begin
      general_relay_o <= (sup_reg == SUP_GEN) && (ts_reg != TS_OPEN);
      safety_relay_o <= sup_reg == SUP_SAF;
      changeover_contact_o <= on_safety_w;
      channel_relay_o <= ch_reg;
      cal_zero_o <= ts_reg == TS_OPEN;
      led_bus_o <= bus_cnt_reg != 32'h00000000;
      led_test_o <= test_on_reg;
      led_fault_o <= fault_reg;
      led_general_o <= sup_reg == SUP_GEN;
      led_safety_o <= sup_reg == SUP_SAF;
      led_channel_o <= ch_reg;
    end
  end
endmodule // scc_top

// ---- tb/scc_central_model.sv ----
`timescale 1ns/10ps
module scc_central_model (
  // clock and answer
  input wire clk_i,
  input wire wb_ack_i,
  // request
  output reg wb_cyc_o = 1'b0,
  output reg wb_stb_o = 1'b0,
  output reg wb_we_o = 1'b0,
  output reg [7:0] wb_adr_o = 8'h00,
  output reg [3:0] wb_sel_o = 4'h0,
  output reg [31:0] wb_dat_o = 32'h0
);
  // ----------------------------------------------------------------
  // central unit bus cycle
  // ----------------------------------------------------------------
  // one classic cycle; released address and data flip so stale values never look valid
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= w;
      wb_adr_o <= a;
      wb_sel_o <= 4'hF;
      wb_dat_o <= d;
      @(posedge clk_i);
      while (!wb_ack_i) @(posedge clk_i);
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_adr_o <= ~a;
      wb_dat_o <= ~d;
    end
  endtask
endmodule // scc_central_model

// ---- tb/scc_top_props.sv ----
`timescale 1ns/10ps
module scc_top_chk #(
  parameter NCH = 8,
  parameter DEAD_CYC = 20
) (
  // clock, reset and bus
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  // field side
  input wire [NCH-1:0] mode_switch_i,
  input wire [9:0] rotary_adr_i,
  input wire general_relay_o,
  input wire safety_relay_o,
  input wire changeover_contact_o,
  input wire [NCH-1:0] channel_relay_o,
  input wire cal_zero_o,
  input wire led_bus_o,
  input wire led_test_o,
  input wire led_safety_o,
  input wire [NCH-1:0] led_channel_o
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reg [31:0] gap_reg;
  // cycles with both supply relays open; the gap must not be cut short
  always @(posedge clk_i) begin
    if (rst_i || general_relay_o || safety_relay_o) gap_reg <= 32'h0;
    else gap_reg <= gap_reg + 32'h1;
  end
  reg [2:0] settle_reg;
  // switch levels need a few cycles through the synchronisers after reset
  always @(posedge clk_i) begin
    if (rst_i) settle_reg <= 3'h0;
    else if (settle_reg != 3'h4) settle_reg <= settle_reg + 3'h1;
  end
  property p_no_overlap; !(general_relay_o && safety_relay_o); endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both supplies closed");
  property p_dead_gap; $rose(safety_relay_o) |-> gap_reg >= DEAD_CYC - 1; endproperty
  a_dead_gap: assert property (p_dead_gap) else $error("dead gap too short");
  property p_contact_av; general_relay_o |-> !changeover_contact_o; endproperty
  a_contact_av: assert property (p_contact_av) else $error("contact not idle");
  property p_contact_sv; safety_relay_o |-> changeover_contact_o; endproperty
  a_contact_sv: assert property (p_contact_sv) else $error("contact idle");
  property p_led_sv; $rose(safety_relay_o) |-> ##[0:1] led_safety_o; endproperty
  a_led_sv: assert property (p_led_sv) else $error("safety led dark");
  property p_led_ch; led_channel_o == channel_relay_o; endproperty
  a_led_ch: assert property (p_led_ch) else $error("channel led wrong");
  property p_all_on; safety_relay_o |-> &channel_relay_o; endproperty
  a_all_on: assert property (p_all_on) else $error("channel off on safety");
  property p_cal; cal_zero_o |-> led_test_o && !general_relay_o && channel_relay_o == 0; endproperty
  a_cal: assert property (p_cal) else $error("zeroing with load");
  property p_steady;
    settle_reg == 3'h4 && general_relay_o && !led_test_o |->
      (channel_relay_o & $past(mode_switch_i, 3)) == $past(mode_switch_i, 3);
  endproperty
  a_steady: assert property (p_steady) else $error("steady channel off");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no bus answer");
  property p_bus_led;
    wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_dat_i[3] &&
      $past(rotary_adr_i, 3) != 10'h000 && $past(rotary_adr_i, 3) <= 10'h3E7
      |-> ##[0:2] led_bus_o;
  endproperty
  a_bus_led: assert property (p_bus_led) else $error("bus led dark");
  // main scenarios
  c_change: cover property ($rose(safety_relay_o));
  c_cal: cover property ($rose(cal_zero_o));
  c_test: cover property ($fell(led_test_o));
endmodule // scc_top_chk
bind scc_top scc_top_chk #(.NCH(NCH), .DEAD_CYC(DEAD_CYC)) u_scc_top_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .mode_switch_i(mode_switch_i), .rotary_adr_i(rotary_adr_i),
  .general_relay_o(general_relay_o),
  .safety_relay_o(safety_relay_o), .changeover_contact_o(changeover_contact_o),
  .channel_relay_o(channel_relay_o), .cal_zero_o(cal_zero_o), .led_bus_o(led_bus_o),
  .led_test_o(led_test_o), .led_safety_o(led_safety_o), .led_channel_o(led_channel_o));

// ---- tb/scc_top_test.sv ----
`timescale 1ns/10ps
module scc_top_test;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  reg clk_i = 1'b0, rst_i = 1'b1, gok = 1'b1, tc = 1'b1, tbn = 1'b0;
  reg [7:0] ls = 8'h00, ms = 8'h0F, me = 8'hF0, cur = 8'hFF, r, tgt;
  reg [9:0] rot = 10'h005;
  reg [31:0] seed = 32'h9718;
  reg [63:0] e;
  reg [63:0] expq[$];
  integer err_count = 0, num_checks = 0, cyc_n = 0, i;
  wire cyc, stb, we, ack, gr, sr, co, lb, lt, lf, lg;
  wire [7:0] adr, ch;
  wire [3:0] sel;
  wire [31:0] dw, dr;
  scc_central_model u_scc_central_model (.clk_i(clk_i), .wb_ack_i(ack), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dw));
  scc_top #(.DEAD_CYC(20), .DEB_CYC(4), .CAL_CYC(8), .BUS_CYC(16)) u_scc_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .general_ok_i(gok), .test_contact_i(tc), .test_button_i(tbn), .light_switch_i(ls),
    .mode_switch_i(ms), .monitor_en_i(me), .rotary_adr_i(rot), .current_ok_i(cur),
    .general_relay_o(gr), .safety_relay_o(sr), .changeover_contact_o(co),
    .channel_relay_o(ch), .cal_zero_o(), .led_bus_o(lb), .led_test_o(lt),
    .led_fault_o(lf), .led_general_o(lg), .led_safety_o(), .led_channel_o());
  initial forever #4 clk_i = ~clk_i;
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // pin levels share the mismatch count with the read checks
  task chk_pin(input [31:0] got, input [31:0] exp);
    chk(got, exp);
  endtask
  task complete_run;
    begin
      if (err_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task w(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    u_scc_central_model.xfer(1'b1, a, d);
  endtask
  // read data is judged by the watcher when the answer arrives
  task rd(input [7:0] a, input [31:0] m, input [31:0] x);
    begin
      expq.push_back({m, x});
      u_scc_central_model.xfer(1'b0, a, 32'h0);
    end
  endtask
  // watcher of read answers, plus the hang limit
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (ack && !we && expq.size() > 0) begin
      e = expq.pop_front();
      chk(dr & e[63:32], e[31:0]);
    end
    if (cyc_n == 4000) begin
      err_count = err_count + 1;
      complete_run;
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    w(2);
    seed = xs(seed);
    rst_i <= 1'b0;
    ls <= seed[7:0];
    w(10);
    chk_pin(ch, ms | ls);
    rd(8'h04, 32'h1F, 32'h12);
    seed = xs(seed);
    r = seed[7:0];
    tgt = ms | ls | r;
    wr(8'h08, seed);
    rd(8'h08, 32'hFF, r);
    rd(8'h0C, 32'hFFFF, {tgt, ms});
    rd(8'h3C, 32'hFFFFFFFF, 32'h0);
    rot <= 10'h000;
    w(3); // address passes the pin synchroniser first
    wr(8'h08, 32'hFF);
    rd(8'h08, 32'hFF, r);
    rd(8'h04, 32'h10, 32'h0);
    rot <= 10'h3E7;
    w(3);
    wr(8'h00, 32'h8);
    w(2);
    chk_pin(lb, 1);
    cur <= 8'h0F;
    wr(8'h00, 32'h1);
    w(40);
    chk_pin({lf, lt, gr, ch}, 11'h7FF);
    rd(8'h10, 32'hFF, 32'hF0);
    rd(8'h04, 32'h8, 32'h8);
    wr(8'h00, 32'h2);
    w(4);
    chk_pin({lt, ch}, {1'b0, tgt});
    for (i = 0; i < 2; i = i + 1) begin
      tbn <= 1'b1;
      w(8);
      tbn <= 1'b0;
      w(40);
      chk_pin({lt, gr, ch}, i ? {2'b01, tgt} : 10'h3FF);
    end
    cur <= 8'hFF;
    // open contact first, then a real supply loss
    for (i = 0; i < 2; i = i + 1) begin
      if (i) gok <= 1'b0;
      else tc <= 1'b0;
      w(40);
      chk_pin({lg, sr, gr, co, ch}, 12'h5FF);
      rd(8'h04, 32'h3, 32'h1);
      gok <= 1'b1;
      tc <= 1'b1;
      w(40);
      chk_pin({lg, sr, gr, co, ch}, {4'b1010, tgt});
    end
    complete_run;
  end
endmodule // scc_top_test
